/* File: hw/fbcp_addr_decode.sv */
// address space and program block decoder
`timescale 1ns/1ps
module fbcp_addr_decode #(
  parameter logic [21:0] DEVID_ADDR = fbcp_pkg::DEVID_ADDR_DEF
) (
  input wire logic [21:0] addr,
  input wire logic size_32k,
  output fbcp_pkg::fbcp_space_t space,
  output logic [2:0] blk
);
  always_comb
  begin
    space = fbcp_pkg::SP_NONE;
    blk = fbcp_pkg::BLK_BOOT;
    if (addr < fbcp_pkg::BOOT_END) // [RULE1]
    begin
      space = fbcp_pkg::SP_PROG;
    end
    else if (addr < fbcp_pkg::BLK0_END) // [RULE2]
    begin
      space = fbcp_pkg::SP_PROG;
      blk = fbcp_pkg::BLK_0;
    end
    else if (addr < fbcp_pkg::BLK1_END)
    begin
      space = fbcp_pkg::SP_PROG;
      blk = fbcp_pkg::BLK_1;
    end
    else if (addr < fbcp_pkg::BLK3_END) // [RULE2]
    begin
      // blocks 2 and 3 exist only on the larger array
      space = size_32k ? fbcp_pkg::SP_PROG : fbcp_pkg::SP_NONE;
      blk = (addr < fbcp_pkg::BLK2_END) ? fbcp_pkg::BLK_2 : fbcp_pkg::BLK_3;
    end
    else if (addr >= fbcp_pkg::ID_BASE && addr < fbcp_pkg::ID_END)
    begin
      space = fbcp_pkg::SP_ID;
    end
    else if (addr >= fbcp_pkg::CFG_EXT_LO && addr <= fbcp_pkg::CFG_RD_HI)
    begin
      space = fbcp_pkg::SP_LOCK;
    end
    else if (addr[21:8] == fbcp_pkg::CFG_PAGE)
    begin
      space = fbcp_pkg::SP_CFG;
    end
    else if (addr[21:1] == DEVID_ADDR[21:1])
    begin
      space = fbcp_pkg::SP_DEVID;
    end
  end
endmodule

/* File: hw/fbcp_pkg.sv */
// shared constants for the flash block code protection checker
package fbcp_pkg;
  // program memory block boundaries (exclusive ends)
  localparam logic [21:0] BOOT_END = 22'h000800;
  localparam logic [21:0] BLK0_END = 22'h002000;
  localparam logic [21:0] BLK1_END = 22'h004000;
  localparam logic [21:0] BLK2_END = 22'h006000;
  localparam logic [21:0] BLK3_END = 22'h008000;
  // user identification bytes
  localparam logic [21:0] ID_BASE = 22'h200000;
  localparam logic [21:0] ID_END = 22'h200008;
  // configuration space page and protection bytes
  localparam logic [13:0] CFG_PAGE = 14'h3000;
  localparam logic [21:0] CFG_EXT_LO = 22'h300008;
  localparam logic [21:0] CFG_EXT_HI = 22'h300009;
  localparam logic [21:0] CFG_WR_LO = 22'h30000a;
  localparam logic [21:0] CFG_WR_HI = 22'h30000b;
  localparam logic [21:0] CFG_RD_LO = 22'h30000c;
  localparam logic [21:0] CFG_RD_HI = 22'h30000d;
  // field positions inside the high protection bytes
  localparam int EE_BIT = 7;
  localparam int BOOT_BIT = 6;
  localparam int CFG_BIT = 5;
  // block index: boot block, then blocks 0 to 3
  localparam logic [2:0] BLK_BOOT = 3'h0;
  localparam logic [2:0] BLK_0 = 3'h1;
  localparam logic [2:0] BLK_1 = 3'h2;
  localparam logic [2:0] BLK_2 = 3'h3;
  localparam logic [2:0] BLK_3 = 3'h4;
  // unprogrammed value of every protection bit is one
  localparam logic [4:0] LOCKS_RESET = 5'h1f;
  localparam logic FLAG_RESET = 1'b1;
  localparam logic [3:0] IMPL_LARGE = 4'hf;
  localparam logic [3:0] IMPL_SMALL = 4'h3;
  // arbitrary neutral identification values
  localparam logic [21:0] DEVID_ADDR_DEF = 22'h3ffffe;
  localparam logic [15:0] DEVICE_ID_DEF = 16'h0000;

  typedef enum logic [2:0] {
    SP_NONE = 3'b000,
    SP_PROG = 3'b001,
    SP_ID = 3'b010,
    SP_LOCK = 3'b011,
    SP_CFG = 3'b100,
    SP_DEVID = 3'b101
  } fbcp_space_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FLASH = 1'b1
  } fbcp_state_t;
endpackage

/* File: hw/fbcp_protect.sv */
// table access protection checker for program flash, eeprom and config
//
// Functional notes
// [RULE1] boot block 000h-7FFh, three or five blocks
// [RULE2] blocks 0-3 at fixed binary boundaries
// [RULE3] each block has three own lock bits
// [RULE4] lock bytes at 300008h to 30000Dh
// [RULE5] table ops reach flash, id, config
// [RULE6] external lock only blocks programmer access
// [RULE7] write lock zero refuses table writes
// [RULE8] same-block table read still returns data
// [RULE9] foreign table read denied, returns zeros
// [RULE10] lock bits only go one to zero
// [RULE11] only programmer erase sets locks back; reset also reloads every lock to one
// [RULE12] eeprom external lock blocks programmer access
// [RULE13] eeprom write lock blocks all writes
// [RULE14] core eeprom reads always allowed
// [RULE15] config write lock, read-only to core
// [RULE16] eight id bytes read and written
// [RULE17] id bytes readable under code protection
// [RULE18] clock, data, program-voltage pins used
// [RULE19] debug bit zero reserves serial pins
// [RULE20] unimplemented lock bits read zero
// [RULE21] unprogrammed locks read one, clear only
// [RULE22] source block from pc, target from pointer
`timescale 1ns/1ps
module fbcp_protect #(
  parameter logic [21:0] DEVID_ADDR = fbcp_pkg::DEVID_ADDR_DEF,
  parameter logic [15:0] DEVICE_ID = fbcp_pkg::DEVICE_ID_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic size_32k,
  input wire logic debug_config_bit,
  input wire logic master_clear_program_voltage_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic serial_clock_sync,
  output logic serial_data_sync,
  input wire logic proto_data_out,
  input wire logic proto_data_oe,
  output logic program_mode,
  output logic debugger_enable,
  output logic serial_pins_reserved,
  input wire logic core_req,
  input wire logic core_write,
  input wire logic [21:0] core_addr,
  input wire logic [21:0] core_pc,
  input wire logic [7:0] core_wdata,
  output logic core_ready,
  input wire logic prog_req,
  input wire logic prog_write,
  input wire logic [21:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_erase,
  input wire logic prog_erase_all,
  input wire logic [2:0] prog_erase_blk,
  output logic prog_ready,
  output logic rsp_done,
  output logic rsp_denied,
  output logic [7:0] rsp_rdata,
  output logic flash_req,
  output logic flash_we,
  output logic [21:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  output logic ee_core_read_ok,
  output logic ee_core_write_ok,
  output logic ee_ext_read_ok,
  output logic ee_ext_write_ok
);
  typedef struct packed {
    fbcp_pkg::fbcp_state_t state;
    logic [1:0] vpp_sync, sclk_sync, sdat_sync;
    logic [4:0] ext_lock, wr_lock, rd_lock;
    logic ee_ext, ee_wr, cfg_wr, dbg_en, rsp_done, rsp_denied;
    logic [7:0] rsp_rdata;
    logic flash_req, flash_we;
    logic [21:0] flash_addr;
    logic [7:0] flash_wdata;
    logic sdat_out, sdat_oe;
  } fbcp_regs_t;

  fbcp_regs_t r, next_r;
  fbcp_pkg::fbcp_space_t t_space, s_space;
  logic [2:0] t_blk, s_blk;
  logic take, take_erase, a_write, ok, to_flash;
  logic [21:0] a_addr;
  logic [7:0] a_wdata;
  logic [7:0] rbyte;
  logic [3:0] impl;

  // source block from the executing instruction, target from the pointer
  fbcp_addr_decode #(.DEVID_ADDR(DEVID_ADDR)) u_tgt (
    .addr(a_addr),
    .size_32k(size_32k),
    .space(t_space),
    .blk(t_blk)
  ); // [RULE22]
  fbcp_addr_decode #(.DEVID_ADDR(DEVID_ADDR)) u_src (
    .addr(core_pc),
    .size_32k(size_32k),
    .space(s_space),
    .blk(s_blk)
  ); // [RULE22]

  assign program_mode = r.vpp_sync[1];
  assign serial_clock_sync = r.sclk_sync[1];
  assign serial_data_sync = r.sdat_sync[1];
  assign serial_data_pin_out = r.sdat_out;
  assign serial_data_pin_oe = r.sdat_oe;
  assign debugger_enable = r.dbg_en;
  assign serial_pins_reserved = r.dbg_en | r.vpp_sync[1];
  assign core_ready = (r.state == fbcp_pkg::ST_IDLE) && !r.vpp_sync[1];
  assign prog_ready = (r.state == fbcp_pkg::ST_IDLE) && r.vpp_sync[1];
  assign rsp_done = r.rsp_done;
  assign rsp_denied = r.rsp_denied;
  assign rsp_rdata = r.rsp_rdata;
  assign flash_req = r.flash_req;
  assign flash_we = r.flash_we;
  assign flash_addr = r.flash_addr;
  assign flash_wdata = r.flash_wdata;
  assign take_erase = prog_ready && prog_erase;
  assign take = (core_ready && core_req) || (prog_ready && prog_req && !prog_erase);
  assign a_write = r.vpp_sync[1] ? prog_write : core_write;
  assign a_addr = r.vpp_sync[1] ? prog_addr : core_addr;
  assign a_wdata = r.vpp_sync[1] ? prog_wdata : core_wdata;
  // core eeprom reads are never gated
  assign ee_core_read_ok = 1'b1; // [RULE14]
  assign ee_core_write_ok = r.ee_wr; // [RULE13]
  assign ee_ext_read_ok = r.ee_ext; // [RULE12]
  assign ee_ext_write_ok = r.ee_ext & r.ee_wr; // [RULE12] [RULE13]

  always_comb
  begin
    next_r = r;
    next_r.vpp_sync = {r.vpp_sync[0], master_clear_program_voltage_pin}; // [RULE18]
    next_r.sclk_sync = {r.sclk_sync[0], serial_clock_pin}; // [RULE18]
    next_r.sdat_sync = {r.sdat_sync[0], serial_data_pin_in}; // [RULE18]
    next_r.dbg_en = !debug_config_bit; // [RULE19]
    // data pin driven only while programming or debugging owns it
    next_r.sdat_out = proto_data_out;
    next_r.sdat_oe = proto_data_oe & (r.vpp_sync[1] | r.dbg_en); // [RULE19]
    next_r.rsp_done = 1'b0;
    next_r.flash_req = 1'b0;
    impl = size_32k ? fbcp_pkg::IMPL_LARGE : fbcp_pkg::IMPL_SMALL;
    ok = 1'b0;
    to_flash = 1'b0;
    rbyte = 8'h00;
    case (a_addr)
      fbcp_pkg::CFG_EXT_LO: rbyte = {4'h0, r.ext_lock[4:1] & impl}; // [RULE4] [RULE20]
      fbcp_pkg::CFG_EXT_HI: rbyte = {r.ee_ext, r.ext_lock[0], 6'h00}; // [RULE4] [RULE20]
      fbcp_pkg::CFG_WR_LO: rbyte = {4'h0, r.wr_lock[4:1] & impl}; // [RULE4] [RULE20]
      fbcp_pkg::CFG_WR_HI: rbyte = {r.ee_wr, r.wr_lock[0], r.cfg_wr, 5'h00}; // [RULE4] [RULE20]
      fbcp_pkg::CFG_RD_LO: rbyte = {4'h0, r.rd_lock[4:1] & impl}; // [RULE4] [RULE20]
      fbcp_pkg::CFG_RD_HI: rbyte = {1'b0, r.rd_lock[0], 6'h00}; // [RULE4] [RULE20]
      default: rbyte = 8'h00;
    endcase
    case (t_space)
      fbcp_pkg::SP_PROG:
      begin
        if (r.vpp_sync[1])
        begin
          ok = r.ext_lock[t_blk] & (!a_write | r.wr_lock[t_blk]); // [RULE6] [RULE3]
        end
        else if (a_write)
        begin
          ok = r.wr_lock[t_blk]; // [RULE7]
        end
        else
        begin
          ok = r.rd_lock[t_blk] | (s_space == fbcp_pkg::SP_PROG && s_blk == t_blk); // [RULE8] [RULE9]
        end
        to_flash = ok; // [RULE5]
      end
      fbcp_pkg::SP_ID:
      begin
        // id bytes ignore every program block lock
        ok = 1'b1; // [RULE16] [RULE17]
        to_flash = 1'b1;
      end
      fbcp_pkg::SP_LOCK, fbcp_pkg::SP_CFG:
      begin
        ok = !a_write || r.vpp_sync[1] || r.cfg_wr; // [RULE15]
        to_flash = ok && t_space == fbcp_pkg::SP_CFG; // [RULE5]
      end
      fbcp_pkg::SP_DEVID:
      begin
        ok = !a_write; // [RULE5]
        rbyte = a_addr[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
      end
      default:
      begin
        // unimplemented space: reads give zeros, writes are dropped
        ok = !a_write;
      end
    endcase
    case (r.state)
      fbcp_pkg::ST_IDLE:
      begin
        if (take_erase)
        begin
          // erase restores locks; only reachable with programming voltage
          if (prog_erase_all)
          begin
            next_r.ext_lock = fbcp_pkg::LOCKS_RESET; // [RULE11]
            next_r.wr_lock = fbcp_pkg::LOCKS_RESET;
            next_r.rd_lock = fbcp_pkg::LOCKS_RESET;
            next_r.ee_ext = fbcp_pkg::FLAG_RESET;
            next_r.ee_wr = fbcp_pkg::FLAG_RESET;
            next_r.cfg_wr = fbcp_pkg::FLAG_RESET;
          end
          else if (prog_erase_blk <= fbcp_pkg::BLK_3)
          begin
            next_r.ext_lock[prog_erase_blk] = 1'b1; // [RULE11]
            next_r.wr_lock[prog_erase_blk] = 1'b1;
            next_r.rd_lock[prog_erase_blk] = 1'b1;
          end
          next_r.rsp_done = 1'b1;
          next_r.rsp_denied = 1'b0;
          next_r.rsp_rdata = 8'h00;
        end
        else if (take)
        begin
          next_r.rsp_denied = !ok;
          // denied reads must not leak stale data
          next_r.rsp_rdata = ok ? rbyte : 8'h00; // [RULE9]
          if (to_flash)
          begin
            next_r.flash_req = 1'b1;
            next_r.flash_we = a_write;
            next_r.flash_addr = a_addr;
            next_r.flash_wdata = a_wdata;
            next_r.state = fbcp_pkg::ST_FLASH;
          end
          else
          begin
            next_r.rsp_done = 1'b1;
          end
          if (ok && a_write && t_space == fbcp_pkg::SP_LOCK)
          begin
            // and-ing makes every lock clear-only
            case (a_addr)
              fbcp_pkg::CFG_EXT_LO: next_r.ext_lock[4:1] = r.ext_lock[4:1] & a_wdata[3:0]; // [RULE10] [RULE21]
              fbcp_pkg::CFG_EXT_HI:
              begin
                next_r.ee_ext = r.ee_ext & a_wdata[fbcp_pkg::EE_BIT]; // [RULE10]
                next_r.ext_lock[0] = r.ext_lock[0] & a_wdata[fbcp_pkg::BOOT_BIT];
              end
              fbcp_pkg::CFG_WR_LO: next_r.wr_lock[4:1] = r.wr_lock[4:1] & a_wdata[3:0]; // [RULE10]
              fbcp_pkg::CFG_WR_HI:
              begin
                next_r.ee_wr = r.ee_wr & a_wdata[fbcp_pkg::EE_BIT]; // [RULE10]
                next_r.wr_lock[0] = r.wr_lock[0] & a_wdata[fbcp_pkg::BOOT_BIT];
                if (r.vpp_sync[1])
                begin
                  next_r.cfg_wr = r.cfg_wr & a_wdata[fbcp_pkg::CFG_BIT]; // [RULE15]
                end
              end
              fbcp_pkg::CFG_RD_LO: next_r.rd_lock[4:1] = r.rd_lock[4:1] & a_wdata[3:0]; // [RULE10]
              fbcp_pkg::CFG_RD_HI: next_r.rd_lock[0] = r.rd_lock[0] & a_wdata[fbcp_pkg::BOOT_BIT];
              default: next_r.ee_wr = r.ee_wr;
            endcase
          end
        end
      end
      fbcp_pkg::ST_FLASH:
      begin
        // array answers in the same cycle as the strobe
        next_r.rsp_rdata = r.flash_we ? 8'h00 : flash_rdata; // [RULE8]
        next_r.rsp_done = 1'b1;
        next_r.state = fbcp_pkg::ST_IDLE;
      end
      default: next_r.state = fbcp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.state <= fbcp_pkg::ST_IDLE;
      r.ext_lock <= fbcp_pkg::LOCKS_RESET; // [RULE21]
      r.wr_lock <= fbcp_pkg::LOCKS_RESET;
      r.rd_lock <= fbcp_pkg::LOCKS_RESET;
      r.ee_ext <= fbcp_pkg::FLAG_RESET;
      r.ee_wr <= fbcp_pkg::FLAG_RESET;
      r.cfg_wr <= fbcp_pkg::FLAG_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic [17:0] all_locks;
  assign all_locks = {r.ext_lock, r.wr_lock, r.rd_lock, r.ee_ext, r.ee_wr, r.cfg_wr};

  boot_map_a: assert property (take && a_addr < 22'h000800 |-> t_space == fbcp_pkg::SP_PROG && t_blk == 3'h0) // [RULE1]
    else $error("boot block decode wrong");
  small_map_a: assert property (take && !size_32k && a_addr >= 22'h004000 && a_addr < 22'h008000
    |=> rsp_done && rsp_rdata == 8'h00 && !flash_req) // [RULE2]
    else $error("small array upper blocks not empty");
  write_lock_a: assert property (take && !program_mode && a_write && t_space == fbcp_pkg::SP_PROG
    && !r.wr_lock[t_blk] |=> rsp_done && rsp_denied && !flash_req) // [RULE7]
    else $error("locked block accepted a table write");
  foreign_read_a: assert property (take && !program_mode && !a_write && t_space == fbcp_pkg::SP_PROG
    && !r.rd_lock[t_blk] && !(s_space == fbcp_pkg::SP_PROG && s_blk == t_blk)
    |=> rsp_done && rsp_denied && rsp_rdata == 8'h00) // [RULE9]
    else $error("foreign table read not blocked");
  own_read_a: assert property (take && !program_mode && !a_write && t_space == fbcp_pkg::SP_PROG
    && s_space == fbcp_pkg::SP_PROG && s_blk == t_blk |=> flash_req ##1 rsp_done && !rsp_denied) // [RULE8]
    else $error("same block table read refused");
  ext_lock_a: assert property (take && program_mode && t_space == fbcp_pkg::SP_PROG
    && !r.ext_lock[t_blk] |=> rsp_denied && !flash_req) // [RULE6]
    else $error("programmer reached a locked block");
  clear_only_a: assert property (!take_erase |=> (all_locks & ~$past(all_locks)) == 18'h00000) // [RULE10]
    else $error("lock bit rose without erase");
  erase_all_a: assert property (take_erase && prog_erase_all |=> all_locks == 18'h3ffff ##0 rsp_done) // [RULE11]
    else $error("chip erase did not restore locks");
  cfg_lock_a: assert property (take && !program_mode && a_write && !r.cfg_wr
    && (t_space == fbcp_pkg::SP_LOCK || t_space == fbcp_pkg::SP_CFG) |=> rsp_denied && $stable(all_locks)) // [RULE15]
    else $error("core wrote locked configuration");
  id_read_a: assert property (take && t_space == fbcp_pkg::SP_ID |=> flash_req && !rsp_denied) // [RULE17]
    else $error("id location blocked");
  ee_write_a: assert property (!r.ee_wr |-> !ee_core_write_ok && !ee_ext_write_ok) // [RULE13]
    else $error("eeprom write open under write lock");
  debug_pin_a: assert property ($fell(debug_config_bit) |=> debugger_enable && serial_pins_reserved) // [RULE19]
    else $error("debugger did not claim serial pins");
endmodule

/* File: testbench/fbcp_flash_model.sv */
// partner model: byte-wide program flash behind the protection checker
`timescale 1ns/1ps
module fbcp_flash_model (
  input wire logic clk,
  input wire logic flash_req,
  input wire logic flash_we,
  input wire logic [21:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  output logic [7:0] flash_rdata
);
  // small array, indexed by a few address bits; the bench keeps its addresses distinct
  logic [7:0] mem [0:511];
  logic [7:0] last;
  logic [8:0] idx;
  assign idx = {flash_addr[21:20], flash_addr[14:8]};
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'hff;
    last = 8'h00;
  end
  // outside a request the data is not held: show the inverse of the last value
  always_comb
    flash_rdata = flash_req ? mem[idx] : ~last;
  always @(posedge clk)
  begin
    if (flash_req && flash_we)
      mem[idx] <= flash_wdata;
    if (flash_req)
      last <= flash_rdata;
  end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the flash block code protection checker
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset = 1, size_32k = 0, debug_config_bit = 1, vpp = 0, sck = 0, sdi = 0, pdo = 0, pdoe = 0;
  logic core_req = 0, core_write = 0, prog_req = 0, prog_write = 0;
  logic prog_erase = 0, prog_erase_all = 0;
  logic [2:0] prog_erase_blk = 3'h0;
  logic [21:0] core_addr = 22'h000000, core_pc = 22'h000000, prog_addr = 22'h000000;
  logic [7:0] core_wdata = 8'h00, prog_wdata = 8'h00;
  logic sdo, sdoe, sck_s, sd_s, program_mode, debugger_enable, serial_pins_reserved, core_ready, prog_ready;
  logic rsp_done, rsp_denied, flash_req, flash_we;
  logic ee_core_read_ok, ee_core_write_ok, ee_ext_read_ok, ee_ext_write_ok;
  logic [7:0] rsp_rdata, flash_wdata, flash_rdata, got_d;
  logic [21:0] flash_addr;
  logic got_den;
  int failures = 0, n_checks = 0, cycles = 0;
  logic [7:0] lock_exp [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};

  always #10 clk = ~clk;

  fbcp_protect uut (.clk(clk), .reset(reset), .size_32k(size_32k), .debug_config_bit(debug_config_bit),
    .master_clear_program_voltage_pin(vpp), .serial_clock_pin(sck), .serial_data_pin_in(sdi),
    .serial_data_pin_out(sdo), .serial_data_pin_oe(sdoe), .serial_clock_sync(sck_s), .serial_data_sync(sd_s),
    .proto_data_out(pdo), .proto_data_oe(pdoe), .program_mode(program_mode), .debugger_enable(debugger_enable),
    .serial_pins_reserved(serial_pins_reserved), .core_req(core_req), .core_write(core_write),
    .core_addr(core_addr), .core_pc(core_pc), .core_wdata(core_wdata), .core_ready(core_ready),
    .prog_req(prog_req), .prog_write(prog_write), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_erase(prog_erase), .prog_erase_all(prog_erase_all), .prog_erase_blk(prog_erase_blk),
    .prog_ready(prog_ready), .rsp_done(rsp_done), .rsp_denied(rsp_denied), .rsp_rdata(rsp_rdata),
    .flash_req(flash_req), .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .ee_core_read_ok(ee_core_read_ok), .ee_core_write_ok(ee_core_write_ok),
    .ee_ext_read_ok(ee_ext_read_ok), .ee_ext_write_ok(ee_ext_write_ok));

  fbcp_flash_model mem (.clk(clk), .flash_req(flash_req), .flash_we(flash_we), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));

  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    // whole run needs a few hundred cycles
    if (cycles == 5000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic reset_dut(input logic big);
    @(posedge clk);
    reset <= 1'b1;
    size_32k <= big;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
  endtask

  // kind 0 core op, 1 programmer op, 2 erase (w selects chip erase, a[2:0] the block)
  task automatic op(input int kind, input logic w, input logic [21:0] a, input logic [21:0] pc,
                    input logic [7:0] d);
    int n;
    @(posedge clk);
    if (kind == 0)
    begin
      core_req <= 1'b1;
      core_write <= w;
      core_addr <= a;
      core_pc <= pc;
      core_wdata <= d;
    end
    else if (kind == 1)
    begin
      prog_req <= 1'b1;
      prog_write <= w;
      prog_addr <= a;
      prog_wdata <= d;
    end
    else
    begin
      prog_erase <= 1'b1;
      prog_erase_all <= w;
      prog_erase_blk <= a[2:0];
    end
    n = 0;
    @(negedge clk);
    while ((kind == 0 ? core_ready : prog_ready) !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    core_req <= 1'b0;
    prog_req <= 1'b0;
    prog_erase <= 1'b0;
    n = 0;
    @(negedge clk);
    while (rsp_done !== 1'b1 && n < 10)
    begin
      n++;
      @(negedge clk);
    end
    chk1(rsp_done, 1'b1);
    got_d = rsp_rdata;
    got_den = rsp_denied;
  endtask

  task automatic acc(input int kind, input logic w, input logic [21:0] a, input logic [21:0] pc,
                     input logic [7:0] d, input logic [7:0] exp, input logic den);
    op(kind, w, a, pc, d);
    if (!w)
      chk8(got_d, exp);
    chk1(got_den, den);
  endtask

  initial
  begin
    reset_dut(1'b0);
    acc(0, 0, 22'h300008, 22'h000100, 8'h00, 8'h03, 0);
    acc(0, 0, 22'h30000c, 22'h000100, 8'h00, 8'h03, 0);
    acc(0, 0, 22'h004100, 22'h000100, 8'h00, 8'h00, 0);
    reset_dut(1'b1);
    for (int i = 0; i < 6; i++)
      acc(0, 0, 22'h300008 + 22'(i), 22'h000100, 8'h00, lock_exp[i], 0);
    acc(0, 1, 22'h000900, 22'h000100, 8'h5a, 8'h00, 0);
    acc(0, 0, 22'h000900, 22'h000100, 8'h00, 8'h5a, 0);
    acc(0, 1, 22'h006100, 22'h000100, 8'h77, 8'h00, 0);
    acc(0, 0, 22'h006100, 22'h000900, 8'h00, 8'h77, 0);
    acc(0, 1, 22'h30000a, 22'h000100, 8'hfe, 8'h00, 0);
    acc(0, 1, 22'h30000a, 22'h000100, 8'hff, 8'h00, 0);
    acc(0, 0, 22'h30000a, 22'h000100, 8'h00, 8'h0e, 0);
    acc(0, 1, 22'h000900, 22'h000100, 8'ha5, 8'h00, 1);
    acc(0, 0, 22'h000900, 22'h000100, 8'h00, 8'h5a, 0);
    acc(0, 1, 22'h30000c, 22'h000100, 8'hfe, 8'h00, 0);
    acc(0, 0, 22'h000900, 22'h000a00, 8'h00, 8'h5a, 0);
    acc(0, 0, 22'h000900, 22'h002100, 8'h00, 8'h00, 1);
    acc(0, 0, 22'h000900, 22'h000100, 8'h00, 8'h00, 1);
    acc(0, 1, 22'h200003, 22'h000100, 8'h3c, 8'h00, 0);
    acc(0, 0, 22'h200003, 22'h000100, 8'h00, 8'h3c, 0);
    acc(0, 1, 22'h30000b, 22'h000100, 8'hdf, 8'h00, 0);
    acc(0, 0, 22'h30000b, 22'h000100, 8'h00, 8'he0, 0);
    acc(0, 1, 22'h30000b, 22'h000100, 8'h7f, 8'h00, 0);
    acc(0, 0, 22'h30000b, 22'h000100, 8'h00, 8'h60, 0);
    acc(0, 0, fbcp_pkg::DEVID_ADDR_DEF, 22'h000100, 8'h00, fbcp_pkg::DEVICE_ID_DEF[7:0], 0);
    acc(0, 0, fbcp_pkg::DEVID_ADDR_DEF + 22'h1, 22'h000100, 8'h00, fbcp_pkg::DEVICE_ID_DEF[15:8], 0);
    acc(0, 1, fbcp_pkg::DEVID_ADDR_DEF, 22'h000100, 8'h12, 8'h00, 1);
    acc(0, 1, 22'h300001, 22'h000100, 8'h96, 8'h00, 0);
    acc(0, 0, 22'h300001, 22'h000100, 8'h00, 8'h96, 0);
    chk1(ee_core_write_ok, 1'b0);
    chk1(ee_ext_write_ok, 1'b0);
    chk1(ee_core_read_ok, 1'b1);
    @(posedge clk);
    debug_config_bit <= 1'b0;
    pdo <= 1'b1;
    pdoe <= 1'b1;
    sck <= 1'b1;
    sdi <= 1'b1;
    cyc(4);
    chk1(debugger_enable, 1'b1);
    chk1(serial_pins_reserved, 1'b1);
    chk1(sdoe, 1'b1);
    chk1(sdo, 1'b1);
    chk1(sck_s, 1'b1);
    chk1(sd_s, 1'b1);
    @(posedge clk);
    debug_config_bit <= 1'b1;
    cyc(4);
    chk1(sdoe, 1'b0);
    @(posedge clk);
    vpp <= 1'b1;
    cyc(5);
    chk1(program_mode, 1'b1);
    chk1(core_ready, 1'b0);
    acc(1, 1, 22'h300008, 22'h0, 8'hfe, 8'h00, 0);
    acc(1, 0, 22'h000900, 22'h0, 8'h00, 8'h00, 1);
    acc(1, 0, 22'h002100, 22'h0, 8'h00, 8'hff, 0);
    acc(1, 0, 22'h200003, 22'h0, 8'h00, 8'h3c, 0);
    acc(1, 1, 22'h300009, 22'h0, 8'h7f, 8'h00, 0);
    chk1(ee_ext_read_ok, 1'b0);
    acc(1, 1, 22'h30000b, 22'h0, 8'hdf, 8'h00, 0);
    acc(1, 0, 22'h30000b, 22'h0, 8'h00, 8'h40, 0);
    acc(2, 0, 22'h000001, 22'h0, 8'h00, 8'h00, 0);
    acc(1, 0, 22'h300008, 22'h0, 8'h00, 8'h0f, 0);
    acc(1, 0, 22'h30000a, 22'h0, 8'h00, 8'h0f, 0);
    acc(1, 0, 22'h30000c, 22'h0, 8'h00, 8'h0f, 0);
    acc(2, 1, 22'h000000, 22'h0, 8'h00, 8'h00, 0);
    acc(1, 0, 22'h300009, 22'h0, 8'h00, 8'hc0, 0);
    acc(1, 0, 22'h30000b, 22'h0, 8'h00, 8'he0, 0);
    acc(1, 1, 22'h30000b, 22'h0, 8'hdf, 8'h00, 0);
    @(posedge clk);
    vpp <= 1'b0;
    cyc(5);
    chk1(core_ready, 1'b1);
    chk1(prog_ready, 1'b0);
    acc(0, 1, 22'h300001, 22'h000100, 8'h00, 8'h00, 1);
    acc(0, 1, 22'h30000a, 22'h000100, 8'h00, 8'h00, 1);
    acc(0, 0, 22'h300001, 22'h000100, 8'h00, 8'h96, 0);
    acc(0, 0, 22'h30000a, 22'h000100, 8'h00, 8'h0f, 0);
    finish_test();
  end
endmodule
